// ---- mmet_pkg.sv ----
// Purpose: Shared constants and types for the multi mode event timer.
// Assumes: One 50 MHz clock; times are held in milliseconds.
// Notes:   Register map, field positions and timing figures live here.
package mmet_pkg;

  // Clock rate and sample tick period.
  localparam int unsigned CLK_KHZ      = 50_000;               // Clock rate in kHz.
  localparam int unsigned TICK_MS      = 110;                  // Sample tick period in ms.
  localparam int unsigned TICK_CYCLES  = CLK_KHZ * TICK_MS;    // Clock cycles per tick.

  // Number of timer channels and width of time values.
  localparam int unsigned NUM_CH       = 4;                    // Independent timer channels.
  localparam int unsigned TW           = 29;                   // Bits of a millisecond time.
  localparam logic [TW-1:0] TIME_MAX   = 29'h1575_299C;        // 99:59:59.9 in ms.
  localparam logic [TW-1:0] TICK_STEP  = 29'h0000_006E;        // Milliseconds added per tick.
  localparam logic [TW-1:0] TIME_ZERO  = 29'h0000_0000;        // Zero time.

  // APB register map: each channel owns a block of four words.
  localparam int unsigned AW           = 8;                    // Address width used.
  localparam logic [1:0]  REG_CTRL     = 2'h0;                 // Mode select, offset 0x0.
  localparam logic [1:0]  REG_TIME     = 2'h1;                 // Duration, offset 0x4.
  localparam logic [1:0]  REG_ELAPSED  = 2'h2;                 // Elapsed time, offset 0x8.
  localparam logic [1:0]  REG_STATUS   = 2'h3;                 // Status bits, offset 0xC.
  localparam int unsigned WSEL_LO      = 2;                    // Word select low bit.
  localparam int unsigned CSEL_LO      = 4;                    // Channel select low bit.
  localparam int unsigned HIGH_LO      = 6;                    // First address bit out of map.

  // Field positions.
  localparam int unsigned MODE_W       = 3;                    // Width of the mode field.
  localparam int unsigned ST_OUT       = 0;                    // Status: output level.
  localparam int unsigned ST_ACTIVE    = 1;                    // Status: timing active.
  localparam int unsigned ST_INPUT     = 2;                    // Status: filtered input.
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;        // Read value of empty bits.

  // Operating modes, disabled being the reset value.
  typedef enum logic [MODE_W-1:0] {
    MODE_OFF,
    MODE_PULSE,
    MODE_DELAY,
    MODE_ONESHOT,
    MODE_MINON
  } mmet_mode_t;

  // State of one timer channel.
  typedef struct packed {
    logic          out;      // Output level.
    logic          active;   // Timing active flag.
    logic          run;      // Elapsed count is running.
    logic          pulse;    // Output is a one tick pulse.
    logic          prev;     // Input level one cycle ago.
    logic [TW-1:0] elapsed;  // Elapsed time in ms.
    logic [TW-1:0] dur;      // Programmed duration in ms.
  } mmet_chan_t;

  localparam mmet_chan_t CHAN_RESET = '0;                      // Channel state after reset.

endpackage : mmet_pkg

// ---- mmet_sync.sv ----
// Purpose: Three flop synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to I_CLOCK.
// Notes:   The output changes only once the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none
module mmet_sync #(
  parameter int unsigned W = 4                         // Number of bits.
) (
  input  wire logic         i_clk,                     // System clock.
  input  wire logic         i_nrst,                    // Asynchronous reset, active low.
  input  wire logic         i_ce,                      // Clock enable.
  input  wire logic [W-1:0] i_d,                       // Asynchronous inputs.
  output logic      [W-1:0] o_q                        // Filtered synchronous level.
);

  logic [W-1:0] s1;  // First stage, read only by the second.
  logic [W-1:0] s2;  // Second stage.
  logic [W-1:0] s3;  // Third stage.

  // Shift chain; each bit updates the output when stages two and three agree.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      s1  <= i_d;
      s2  <= s1;
      s3  <= s2;
      o_q <= (s2 & s3) | (o_q & (s2 ^ s3));
    end
  end

endmodule // mmet_sync
`default_nettype wire

// ---- mmet_tick.sv ----
// Purpose: Periodic sample tick generator.
// Assumes: Period given in clock cycles.
// Notes:   The tick is a one cycle pulse; counting stops while i_ce is low.
`timescale 1ns/1ns
`default_nettype none
module mmet_tick #(
  parameter int unsigned PERIOD = 5_500_000            // Clock cycles per tick.
) (
  input  wire logic i_clk,                             // System clock.
  input  wire logic i_nrst,                            // Asynchronous reset, active low.
  input  wire logic i_ce,                              // Clock enable.
  output logic      o_tick                             // One cycle tick pulse.
);

  localparam int unsigned CW = $clog2(PERIOD + 1);     // Counter width.
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);    // Final count of a period.

  logic [CW-1:0] cnt;   // Cycles within the current period.
  wire           wrap = (cnt == LAST);  // Period ends this cycle.

  // Count cycles and pulse the tick on the last one.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      cnt    <= wrap ? '0 : cnt + CW'(1);
      o_tick <= wrap;
    end
  end

endmodule // mmet_tick
`default_nettype wire

// ---- mmet_top.sv ----
// Purpose: Four channel multi mode event timer with an APB register file.
// Assumes: One 50 MHz clock; trigger inputs arrive from other logic or pins.
// Notes:   Times are in ms; every count advances on the 110 ms sample tick.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RQ1 - Four independent timers, each with own mode.
// RQ2 - Pulse: input rising edge sets output.
// RQ3 - Pulse: output clears when elapsed reaches duration.
// RQ4 - Pulse: retrigger while on restarts elapsed count.
// RQ5 - Pulse: active flag follows output.
// RQ6 - Delay: rising edge drives output low, counts.
// RQ7 - Delay: after duration output high until input low.
// RQ8 - Delay: early input fall gives one-tick pulse.
// RQ9 - Delay: active from rise until done and low.
// RQ10 - One-shot: non-zero duration write sets output.
// RQ11 - One-shot: duration counts down per tick to zero.
// RQ12 - One-shot: new duration accepted during countdown.
// RQ13 - One-shot: no reload after reaching zero.
// RQ14 - One-shot: input gates countdown and output.
// RQ15 - One-shot: active from write until zero.
// RQ16 - Min-on: input rising edge sets output.
// RQ17 - Min-on: input falling edge starts elapsed count.
// RQ18 - Min-on: output clears when elapsed reaches duration.
// RQ19 - Min-on: input high while on clears count.
// RQ20 - Min-on: active exactly while elapsed nonzero.
// RQ21 - Mode select, disabled after reset.
// RQ22 - Times span 99:59:59.9, tenth resolution; code counts in 110 ms steps per tick.
// RQ23 - All counting steps on one sample tick.
// RQ24 - Disabled mode holds outputs low, elapsed zero.
module mmet_top
  import mmet_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES       // Cycles per sample tick.
) (
  input  wire logic              I_CLOCK,                  // System clock, 50 MHz.
  input  wire logic              I_NRST,                   // Asynchronous reset, active low.
  input  wire logic              I_CE,                     // Clock enable, freezes all state.
  input  wire logic              I_PSEL,                   // APB select.
  input  wire logic              I_PENABLE,                // APB enable.
  input  wire logic              I_PWRITE,                 // APB write direction.
  input  wire logic [AW-1:0]     I_PADDR,                  // APB byte address.
  input  wire logic [31:0]       I_PWDATA,                 // APB write data.
  output logic      [31:0]       O_PRDATA,                 // APB read data.
  output logic                   O_PREADY,                 // APB ready.
  output logic                   O_PSLVERR,                // APB error on unmapped address.
  input  wire logic [NUM_CH-1:0] I_TRIG,                   // Trigger or gate inputs.
  output logic      [NUM_CH-1:0] O_OUT,                    // Timer outputs.
  output logic      [NUM_CH-1:0] O_ACTIVE                  // Timing active flags.
);

  // Saturating add of one tick step; never passes the largest time.
  function automatic logic [TW-1:0] time_add(input logic [TW-1:0] t);
    logic [TW:0] s;
    s = {1'b0, t} + {1'b0, TICK_STEP};
    time_add = (s > {1'b0, TIME_MAX}) ? TIME_MAX : s[TW-1:0];
  endfunction

  // Saturating subtract of one tick step; stops at zero.
  function automatic logic [TW-1:0] time_sub(input logic [TW-1:0] t);
    time_sub = (t > TICK_STEP) ? (t - TICK_STEP) : TIME_ZERO;
  endfunction

  // Clamp a written value to the largest settable time.
  function automatic logic [TW-1:0] time_clamp(input logic [31:0] v);
    time_clamp = (v > {3'b000, TIME_MAX}) ? TIME_MAX : v[TW-1:0];
  endfunction

  // Input filtering and sample tick.
  logic [NUM_CH-1:0] trig_s;   // Filtered trigger levels.
  logic              tick;     // Sample tick pulse.

  // Pins pass a three flop synchroniser before any logic looks at them.
  mmet_sync #(
    .W      (NUM_CH)
  ) u_sync (
    .i_clk  (I_CLOCK),
    .i_nrst (I_NRST),
    .i_ce   (I_CE),
    .i_d    (I_TRIG),
    .o_q    (trig_s)
  );

  // One tick drives every count of every channel.
  mmet_tick #(
    .PERIOD (P_TICK_CYCLES)
  ) u_tick (
    .i_clk  (I_CLOCK),
    .i_nrst (I_NRST),
    .i_ce   (I_CE),
    .o_tick (tick)                                       // [RQ23]
  );

  // APB address decode.
  wire [1:0] wsel     = I_PADDR[WSEL_LO +: 2];           // Word within a channel.
  wire [1:0] csel     = I_PADDR[CSEL_LO +: 2];           // Channel number.
  wire       mapped   = (I_PADDR[AW-1:HIGH_LO] == '0) && (I_PADDR[1:0] == 2'b00);
  logic      loaded;                                     // Read data captured for this transfer.
  wire       access   = I_PSEL && I_PENABLE && loaded;   // Transfer completes this cycle.
  wire       wr_en    = access && I_PWRITE && mapped && I_CE;  // Write takes effect.

  // Ready comes one cycle after read data has been captured.
  assign O_PREADY  = access;
  assign O_PSLVERR = access && !mapped;

  // Channel state, modes and per channel write strobes.
  mmet_chan_t        ch      [NUM_CH];  // Current channel state.
  mmet_chan_t        next_ch [NUM_CH];  // Next channel state.
  mmet_mode_t        mode    [NUM_CH];  // Operating mode of each channel.
  logic [NUM_CH-1:0] wr_ctrl;           // Mode register written.
  logic [NUM_CH-1:0] wr_time;           // Duration register written.
  wire  [TW-1:0]     wval = time_clamp(I_PWDATA);  // Written duration, clamped. [RQ22]

  // Read data selection for the addressed word.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = RD_ZERO;
    if (mapped) begin
      case (wsel)
        REG_CTRL:    rd_word = {{(32-MODE_W){1'b0}}, mode[csel]};
        REG_TIME:    rd_word = {{(32-TW){1'b0}}, ch[csel].dur};
        REG_ELAPSED: rd_word = {{(32-TW){1'b0}}, ch[csel].elapsed};
        REG_STATUS: begin
          rd_word[ST_OUT]    = ch[csel].out;
          rd_word[ST_ACTIVE] = ch[csel].active;
          rd_word[ST_INPUT]  = trig_s[csel];
        end
        default:     rd_word = RD_ZERO;
      endcase
    end
  end

  // Capture read data during setup so the answer comes from a flop.
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PRDATA <= RD_ZERO;
      loaded   <= 1'b0;
    end else if (I_CE) begin
      if (I_PSEL && !access) begin
        O_PRDATA <= rd_word;
        loaded   <= 1'b1;
      end else begin
        loaded   <= 1'b0;
      end
    end
  end

  // Per channel logic, replicated for each of the four timers.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch             // [RQ1]

    // Write strobes for this channel.
    assign wr_ctrl[g] = wr_en && (csel == 2'(g)) && (wsel == REG_CTRL);
    assign wr_time[g] = wr_en && (csel == 2'(g)) && (wsel == REG_TIME);

    // Input edges seen on the filtered level.
    wire rise = trig_s[g] && !ch[g].prev;                // Off to on.
    wire fall = !trig_s[g] && ch[g].prev;                // On to off.
    wire in_s = trig_s[g];                               // Present input level.

    // Next state of the channel for the selected mode.
    always_comb begin
      logic [TW-1:0] el;
      el          = time_add(ch[g].elapsed);
      next_ch[g]  = ch[g];
      next_ch[g].prev = in_s;
      // A duration write always stores the new value.
      if (wr_time[g]) begin
        next_ch[g].dur = wval;                           // [RQ12]
      end
      case (mode[g])
        MODE_PULSE: begin
          if (rise) begin
            // Start or restart the pulse from zero.
            next_ch[g].out     = 1'b1;                   // [RQ2]
            next_ch[g].elapsed = TIME_ZERO;              // [RQ4]
          end else if (tick && ch[g].out) begin
            next_ch[g].elapsed = el;                     // [RQ23]
            if (el >= ch[g].dur) begin
              next_ch[g].out = 1'b0;                     // [RQ3]
            end
          end
          next_ch[g].active = next_ch[g].out;            // [RQ5]
        end
        MODE_DELAY: begin
          if (rise) begin
            // Output held low while the delay runs.
            next_ch[g].out     = 1'b0;                   // [RQ6]
            next_ch[g].run     = 1'b1;
            next_ch[g].pulse   = 1'b0;
            next_ch[g].elapsed = TIME_ZERO;
          end else if (tick && ch[g].run) begin
            next_ch[g].elapsed = el;
            if (el >= ch[g].dur) begin
              // Delay over: hold high, or one tick pulse if input already left.
              next_ch[g].run   = 1'b0;
              next_ch[g].out   = 1'b1;                   // [RQ7]
              next_ch[g].pulse = !in_s;                  // [RQ8]
            end
          end else if (tick && ch[g].pulse) begin
            // The short pulse lasts exactly one tick.
            next_ch[g].out   = 1'b0;                     // [RQ8]
            next_ch[g].pulse = 1'b0;
          end else if (ch[g].out && !ch[g].pulse && !in_s) begin
            next_ch[g].out = 1'b0;                       // [RQ7]
          end
          next_ch[g].active = next_ch[g].run || next_ch[g].out;  // [RQ9]
        end
        MODE_ONESHOT: begin
          next_ch[g].elapsed = TIME_ZERO;
          if (wr_time[g]) begin
            // A non-zero write starts an on period at once.
            next_ch[g].active = (wval != TIME_ZERO);     // [RQ10] [RQ15]
          end else if (tick && in_s && ch[g].active) begin
            // The duration itself counts down; zero ends the period.
            next_ch[g].dur = time_sub(ch[g].dur);        // [RQ11]
            if (time_sub(ch[g].dur) == TIME_ZERO) begin
              next_ch[g].active = 1'b0;                  // [RQ13] [RQ15]
            end
          end
          // The gate input forces the output low while it is off.
          next_ch[g].out = next_ch[g].active && in_s;    // [RQ14]
        end
        MODE_MINON: begin
          if (rise) begin
            // Output on; any running hold time is abandoned.
            next_ch[g].out     = 1'b1;                   // [RQ16]
            next_ch[g].run     = 1'b0;
            next_ch[g].elapsed = TIME_ZERO;              // [RQ19]
          end else if (fall && ch[g].out) begin
            next_ch[g].run = 1'b1;                       // [RQ17]
          end else if (tick && ch[g].run) begin
            next_ch[g].elapsed = el;
            if (el >= ch[g].dur) begin
              // Hold time met: output off and count cleared.
              next_ch[g].out     = 1'b0;                 // [RQ18]
              next_ch[g].run     = 1'b0;
              next_ch[g].elapsed = TIME_ZERO;
            end
          end
          next_ch[g].active = (next_ch[g].elapsed != TIME_ZERO);  // [RQ20]
        end
        default: begin
          // Disabled: everything idle and low.
          next_ch[g].out     = 1'b0;                     // [RQ24]
          next_ch[g].active  = 1'b0;
          next_ch[g].run     = 1'b0;
          next_ch[g].pulse   = 1'b0;
          next_ch[g].elapsed = TIME_ZERO;
        end
      endcase
      // A mode change restarts the channel from idle, keeping the duration.
      if (wr_ctrl[g]) begin
        next_ch[g].out     = 1'b0;
        next_ch[g].active  = 1'b0;
        next_ch[g].run     = 1'b0;
        next_ch[g].pulse   = 1'b0;
        next_ch[g].elapsed = TIME_ZERO;
      end
    end

    // Mode register; unknown codes fall back to disabled.
    wire [MODE_W-1:0] wmode = I_PWDATA[MODE_W-1:0];
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
        mode[g] <= MODE_OFF;                             // [RQ21]
      end else if (I_CE && wr_ctrl[g]) begin
        mode[g] <= (wmode > MODE_MINON) ? MODE_OFF : mmet_mode_t'(wmode);  // [RQ21]
      end
    end

    // Channel state register.
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
        ch[g] <= CHAN_RESET;
      end else if (I_CE) begin
        ch[g] <= next_ch[g];
      end
    end

    // Outputs come straight from the state flops.
    assign O_OUT[g]    = ch[g].out;
    assign O_ACTIVE[g] = ch[g].active;
  end

endmodule // mmet_top
`default_nettype wire

// ---- mmet_top_asserts.sv ----
// Purpose: Port level checks for the four channel event timer.
// Assumes: Mode of each channel is followed by snooping APB writes.
// Notes:   Output checks wait one cycle after a mode change.
`timescale 1ns/1ns
`default_nettype none
module mmet_top_asserts
  import mmet_pkg::*;
(
  input wire logic              I_CLOCK,    // System clock.
  input wire logic              I_NRST,     // Reset, active low.
  input wire logic              I_CE,       // Clock enable.
  input wire logic              I_PSEL,     // APB select.
  input wire logic              I_PENABLE,  // APB enable.
  input wire logic              I_PWRITE,   // APB direction.
  input wire logic [AW-1:0]     I_PADDR,    // APB address.
  input wire logic [31:0]       I_PWDATA,   // APB write data.
  input wire logic [31:0]       O_PRDATA,   // APB read data.
  input wire logic              O_PREADY,   // APB ready.
  input wire logic              O_PSLVERR,  // APB error.
  input wire logic [NUM_CH-1:0] I_TRIG,     // Trigger inputs.
  input wire logic [NUM_CH-1:0] O_OUT,      // Timer outputs.
  input wire logic [NUM_CH-1:0] O_ACTIVE    // Active flags.
);
  logic [NUM_CH-1:0][MODE_W-1:0] mode_q;    // Mode of each channel as written.
  // A completed write to a CTRL word of a mapped channel.
  wire logic wr_ctrl = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_CE
                       && I_PADDR[7:6] == 2'h0 && I_PADDR[3:0] == 4'h0;
  // Codes above the last mode are stored as disabled.
  wire logic [MODE_W-1:0] next_mode = (I_PWDATA[2:0] > 3'h4) ? 3'h0 : I_PWDATA[2:0];

  // Tracks the mode so that output checks know which rules apply.
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      mode_q <= '0;
    end else if (wr_ctrl) begin
      mode_q[I_PADDR[5:4]] <= next_mode;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);

  sequence s_setup;
    I_PSEL && !I_PENABLE && I_CE;
  endsequence
  property p_ready;
    s_setup ##1 (I_PSEL && I_PENABLE) |-> O_PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready missing in access cycle");
  property p_err_zero;
    O_PREADY && O_PSLVERR && !I_PWRITE |-> O_PRDATA == RD_ZERO;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read gave data");
  property p_reset_idle;
    $rose(I_NRST) |-> O_OUT == '0 && O_ACTIVE == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs set after reset");

  // Per channel relations between output, active flag and mode.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    property p_off;
      mode_q[c] == MODE_OFF && $stable(mode_q[c]) |-> !O_OUT[c] && !O_ACTIVE[c];
    endproperty
    a_off: assert property (p_off) else $error("disabled channel not idle");
    property p_pulse;
      mode_q[c] == MODE_PULSE && $stable(mode_q[c]) |-> O_ACTIVE[c] == O_OUT[c];
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse flag differs");
    property p_delay;
      mode_q[c] == MODE_DELAY && $stable(mode_q[c]) && O_OUT[c] |-> O_ACTIVE[c];
    endproperty
    a_delay: assert property (p_delay) else $error("delay out without flag");
    property p_oneshot;
      mode_q[c] == MODE_ONESHOT && $stable(mode_q[c]) && O_OUT[c] |-> O_ACTIVE[c];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("oneshot out without flag");
    property p_minon;
      mode_q[c] == MODE_MINON && $stable(mode_q[c]) && O_ACTIVE[c] |-> O_OUT[c];
    endproperty
    a_minon: assert property (p_minon) else $error("min on flag without out");
  end
endmodule // mmet_top_asserts
`default_nettype wire

// ---- mmet_far.sv ----
// Purpose: Model of the logic that drives the trigger inputs.
// Assumes: The bench sets the wanted level of each line.
// Notes:   Lines change only just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module mmet_far
  import mmet_pkg::*;
(
  input  wire logic              i_clk,   // System clock.
  input  wire logic              i_nrst,  // Reset, active low.
  input  wire logic [NUM_CH-1:0] i_req,   // Levels asked for by the bench.
  output logic      [NUM_CH-1:0] o_trig   // Trigger lines to the timer.
);
  // Registers the asked levels like a neighbouring logic block would.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_trig <= '0;
    end else begin
      o_trig <= i_req;
    end
  end
endmodule // mmet_far
`default_nettype wire

// ---- multi_mode_event_timer_bench.sv ----
// Purpose: Self checking bench of the four channel event timer.
// Assumes: Short tick of 20 cycles for a quick run.
// Notes:   Times are written in ms, 110 ms per tick.
`timescale 1ns/1ns
`default_nettype none
module multi_mode_event_timer_bench
  import mmet_pkg::*;
;
  localparam int TK = 20;                 // Cycles per tick in this run.
  logic              clk, nrst, ce;       // Clock, reset and enable.
  logic              psel, penable, pwrite; // APB controls.
  logic [AW-1:0]     paddr;               // APB address.
  logic [31:0]       pwdata, prdata, rd, q; // Data words.
  logic              pready, pslverr, er; // APB answer.
  logic [NUM_CH-1:0] req, trig, out, act; // Trigger and outputs.
  int                bad_count, cmp_count, n, v; // Counters and scratch.

  mmet_top #(.P_TICK_CYCLES(TK)) dut (.I_CLOCK(clk), .I_NRST(nrst), .I_CE(ce),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TRIG(trig), .O_OUT(out), .O_ACTIVE(act));
  mmet_far far (.i_clk(clk), .i_nrst(nrst), .i_req(req), .o_trig(trig));

  // Clock of 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints the verdict and stops.
  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer; ready and answer are taken at a rising edge.
  task automatic apb(input logic w, input int c, input logic [1:0] r, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {c[3:0], r, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rdc(input int c, input logic [1:0] r, input logic [31:0] e);
    apb(1'b0, c, r, 32'h0000_0000);
    chk(rd, e);
  endtask

  // Counts cycles until a channel output reaches a level.
  task automatic wt(input int c, input logic lv);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (out[c] !== lv);
    @(posedge clk);
  endtask

  // Expected TIME after a write: large values are clamped.
  function automatic logic [31:0] exp_time(input logic [31:0] d);
    return (d > {3'h0, TIME_MAX}) ? {3'h0, TIME_MAX} : d;
  endfunction

  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // Main sequence of scenarios.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req} = '0;
    bad_count = 0;
    cmp_count = 0;
    {nrst, ce} = 2'b01;
    v = $urandom(38);
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      rdc(c, REG_CTRL, 32'h0000_0000);
      rdc(c, REG_STATUS, 32'h0000_0000);
    end
    apb(1'b0, 4, 2'h0, 32'h0000_0000);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // Pulse on channel 0, plain then retriggered.
    apb(1'b1, 0, REG_CTRL, 32'h0000_0001);
    apb(1'b1, 0, REG_TIME, 32'h0000_014A);
    ce <= 1'b0;
    req[0] <= 1'b1;
    repeat (30) @(posedge clk);
    chk(out, 0);
    ce <= 1'b1;
    wt(0, 1'b1);
    wt(0, 1'b0);
    chk(n >= 39 && n <= 60, 1);
    req[0] <= 1'b0;
    repeat (5) @(posedge clk);
    req[0] <= 1'b1;
    wt(0, 1'b1);
    req[0] <= 1'b0;
    repeat (30) @(posedge clk);
    req[0] <= 1'b1;
    wt(0, 1'b0);
    chk(n >= 40 && n <= 70, 1);
    // Delay on channel 1: long input, then a short one.
    apb(1'b1, 1, REG_CTRL, 32'h0000_0002);
    apb(1'b1, 1, REG_TIME, 32'h0000_00DC);
    req[1] <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(1, REG_STATUS, 32'h0000_0006);
    wt(1, 1'b1);
    chk(n >= 14 && n <= 48, 1);
    repeat (40) @(posedge clk);
    rdc(1, REG_STATUS, 32'h0000_0007);
    req[1] <= 1'b0;
    wt(1, 1'b0);
    chk(n <= 8, 1);
    req[1] <= 1'b1;
    repeat (8) @(posedge clk);
    req[1] <= 1'b0;
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk(n, TK);
    rdc(1, REG_STATUS, 32'h0000_0000);
    // One-shot on channel 2 with the input as gate.
    apb(1'b1, 2, REG_CTRL, 32'h0000_0003);
    req[2] <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b1, 2, REG_TIME, 32'h0000_014A);
    wt(2, 1'b1);
    chk(n <= 3, 1);
    apb(1'b1, 2, REG_TIME, 32'h0000_006E);
    wt(2, 1'b0);
    chk(n <= 22, 1);
    rdc(2, REG_TIME, 32'h0000_0000);
    repeat (45) @(posedge clk);
    rdc(2, REG_STATUS, 32'h0000_0004);
    apb(1'b1, 2, REG_TIME, 32'h0000_01B8);
    req[2] <= 1'b0;
    wt(2, 1'b0);
    apb(1'b0, 2, REG_TIME, 32'h0000_0000);
    q = rd;
    repeat (45) @(posedge clk);
    rdc(2, REG_TIME, q);
    rdc(2, REG_STATUS, 32'h0000_0002);
    req[2] <= 1'b1;
    wt(2, 1'b1);
    // Minimum on for channel 3.
    apb(1'b1, 3, REG_CTRL, 32'h0000_0004);
    apb(1'b1, 3, REG_TIME, 32'h0000_00DC);
    req[3] <= 1'b1;
    wt(3, 1'b1);
    rdc(3, REG_STATUS, 32'h0000_0005);
    repeat (45) @(posedge clk);
    rdc(3, REG_ELAPSED, 32'h0000_0000);
    req[3] <= 1'b0;
    wt(3, 1'b0);
    chk(n >= 20 && n <= 48, 1);
    req[3] <= 1'b1;
    wt(3, 1'b1);
    req[3] <= 1'b0;
    repeat (30) @(posedge clk);
    req[3] <= 1'b1;
    repeat (10) @(posedge clk);
    rdc(3, REG_ELAPSED, 32'h0000_0000);
    rdc(3, REG_STATUS, 32'h0000_0005);
    // Random modes and durations, with a clamp corner.
    req <= '0;
    for (int i = 0; i < 12; i++) begin
      v = $urandom % 8;
      apb(1'b1, i % 4, REG_CTRL, v);
      rdc(i % 4, REG_CTRL, (v > 4) ? 0 : v);
      apb(1'b1, i % 4, REG_CTRL, 32'h0000_0000);
      q = (i == 0) ? 32'h1FFF_FFFF : ($urandom & 32'h1FFF_FFFF);
      apb(1'b1, i % 4, REG_TIME, q);
      rdc(i % 4, REG_TIME, exp_time(q));
      rdc(i % 4, REG_STATUS, 32'h0000_0000);
      rdc(i % 4, REG_ELAPSED, 32'h0000_0000);
    end
    apb(1'b1, 3, REG_CTRL, 32'h0000_0004);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(3, REG_CTRL, 32'h0000_0000);
    end_sim();
  end
endmodule // multi_mode_event_timer_bench

bind mmet_top mmet_top_asserts u_chk (.I_CLOCK, .I_NRST,
  .I_CE, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY,
  .O_PSLVERR, .I_TRIG, .O_OUT, .O_ACTIVE);
`default_nettype wire
